/* include/psnvm_pkg.sv */
package psnvm_pkg;
  // Geometry of the memory word port
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  // Bus timing in ns, from which cycle counts are derived at 40 MHz
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETUP_NS = 50;      // Address and select setup before strobe and data drive
  localparam int ACCESS_NS = 150;    // Read access before sampling the bus
  localparam int PULSE_NS = 120;     // Write strobe low time
  localparam int PRECHARGE_NS = 150; // Pre-charge after chip select rises
  localparam int SLEEP_EXIT_NS = 500;
  // Least times round up
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYC = (SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  // Sequencer states
  typedef enum logic [2:0] {
    PSNVM_IDLE, PSNVM_SLEEP, PSNVM_WAKE, PSNVM_RD_ACC, PSNVM_WR_SET,
    PSNVM_WR_PULSE, PSNVM_PRECHG
  } psnvm_state_type;
endpackage : psnvm_pkg

/* rtl/psnvm_host.sv */
`timescale 1ns/10ps
// Summary of operation
// - One shared 16-bit bus, host drives writes
// - Host holds sleep high during accesses
// - Do not drive bus early in write
// - Allow read output at address change
// - Byte selects steady while select low
// - Byte selects low for full words
module psnvm_host
  import psnvm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic req_valid,             // User request, held until ready
  output logic req_ready,                 // Combinational accept
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_byte_en,     // Bit0 low lane, bit1 high lane
  input wire logic sleep_req,             // Level: keep device asleep
  output logic rsp_valid,                 // One-cycle read data pulse
  output logic [DATA_W-1:0] rsp_rdata,
  output logic asleep,                    // Device held in sleep
  output logic [ADDR_W-1:0] word_addr,
  output logic chip_sel_n,
  output logic write_strobe_n,
  output logic out_drive_n,
  output logic low_byte_lane_n,
  output logic high_byte_lane_n,
  output logic sleep_n,
  input wire logic [DATA_W-1:0] data_bus_in,
  output logic [DATA_W-1:0] data_bus_out,
  output logic data_bus_oe
);

  // Sequencer state and counter
  psnvm_state_type state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  // Pin and data registers
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic cs_n_r, cs_n_nxt;
  logic we_n_r, we_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [1:0] lane_n_r, lane_n_nxt;
  logic zz_n_r, zz_n_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic drive_r, drive_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;

  // Load a counter for a least time, minimum one cycle
  function automatic logic [CNT_W-1:0] psnvm_cnt(input int cyc);
    psnvm_cnt = (cyc < 1) ? CNT_ONE : CNT_W'(cyc);
  endfunction : psnvm_cnt

  // Accept only when idle and no sleep is wanted
  assign req_ready = (state_r == PSNVM_IDLE) && !sleep_req;

  // Next-state and pin computation
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r != CNT_ZERO) ? cnt_r - CNT_ONE : CNT_ZERO;
    addr_nxt = addr_r;
    cs_n_nxt = cs_n_r;
    we_n_nxt = we_n_r;
    oe_n_nxt = oe_n_r;
    lane_n_nxt = lane_n_r;
    zz_n_nxt = zz_n_r;
    wdata_nxt = wdata_r;
    drive_nxt = drive_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    case (state_r)
      PSNVM_IDLE: begin
        // Standby: select high, strobes idle
        if (sleep_req) begin
          // Sleep only entered from idle, never mid-access
          zz_n_nxt = 1'b0;
          state_nxt = PSNVM_SLEEP;
        end else if (req_valid) begin
          addr_nxt = req_addr;
          // Lanes move only as select falls or at the end of pre-charge, so they stay put under it
          lane_n_nxt = ~req_byte_en;
          cs_n_nxt = 1'b0;
          cnt_nxt = psnvm_cnt(req_write ? SETUP_CYC : ACCESS_CYC);
          if (req_write) begin
            // Output drive stays high; bus left to the device briefly
            wdata_nxt = req_wdata;
            state_nxt = PSNVM_WR_SET;
          end else begin
            oe_n_nxt = 1'b0;
            state_nxt = PSNVM_RD_ACC;
          end
        end
      end
      PSNVM_SLEEP: begin
        // Select and strobes idle high while asleep; byte lanes stay low
        if (!sleep_req) begin
          zz_n_nxt = 1'b1;
          cnt_nxt = psnvm_cnt(WAKE_CYC);
          state_nxt = PSNVM_WAKE;
        end
      end
      PSNVM_WAKE: begin
        if (cnt_r == CNT_ONE) begin
          state_nxt = PSNVM_IDLE;
        end
      end
      PSNVM_RD_ACC: begin
        if (cnt_r == CNT_ONE) begin
          rdata_nxt = data_bus_in;
          rvalid_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          cs_n_nxt = 1'b1;
          cnt_nxt = psnvm_cnt(PRECHARGE_CYC);
          state_nxt = PSNVM_PRECHG;
        end
      end
      PSNVM_WR_SET: begin
        // Wait out any read output before driving
        if (cnt_r == CNT_ONE) begin
          we_n_nxt = 1'b0;
          drive_nxt = 1'b1;
          cnt_nxt = psnvm_cnt(PULSE_CYC);
          state_nxt = PSNVM_WR_PULSE;
        end
      end
      PSNVM_WR_PULSE: begin
        // Strobe and select rise together; earliest edge latches
        if (cnt_r == CNT_ONE) begin
          we_n_nxt = 1'b1;
          cs_n_nxt = 1'b1;
          cnt_nxt = psnvm_cnt(PRECHARGE_CYC);
          state_nxt = PSNVM_PRECHG;
        end
      end
      PSNVM_PRECHG: begin
        // Data held one cycle past the rising edges for hold time
        drive_nxt = 1'b0;
        if (cnt_r == CNT_ONE) begin
          lane_n_nxt = 2'h0;
          state_nxt = PSNVM_IDLE;
        end
      end
      default: begin
        state_nxt = PSNVM_IDLE;
      end
    endcase
  end

  // Register everything
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= PSNVM_IDLE;
      cnt_r <= CNT_ZERO;
      addr_r <= '0;
      cs_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      lane_n_r <= 2'h0;
      zz_n_r <= 1'b1;
      wdata_r <= '0;
      drive_r <= 1'b0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      cs_n_r <= cs_n_nxt;
      we_n_r <= we_n_nxt;
      oe_n_r <= oe_n_nxt;
      lane_n_r <= lane_n_nxt;
      zz_n_r <= zz_n_nxt;
      wdata_r <= wdata_nxt;
      drive_r <= drive_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Pin outputs straight from flops
  assign word_addr = addr_r;
  assign chip_sel_n = cs_n_r;
  assign write_strobe_n = we_n_r;
  assign out_drive_n = oe_n_r;
  assign low_byte_lane_n = lane_n_r[0];
  assign high_byte_lane_n = lane_n_r[1];
  assign sleep_n = zz_n_r;
  assign data_bus_out = wdata_r;
  assign data_bus_oe = drive_r;
  assign rsp_valid = rvalid_r;
  assign rsp_rdata = rdata_r;
  assign asleep = (state_r == PSNVM_SLEEP);

  // Checks on the pins this host drives
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  a_sleep_high_access: assert property (!chip_sel_n |-> sleep_n)
    else $error("Sleep low during access");
  a_lanes_steady_sel: assert property ((!chip_sel_n && $past(!chip_sel_n))
    |-> $stable({low_byte_lane_n, high_byte_lane_n}))
    else $error("Byte lanes changed under select");
  a_no_early_drive: assert property ($fell(chip_sel_n) && write_strobe_n
    |-> !data_bus_oe [*2])
    else $error("Bus driven too early in write");
  a_no_contention: assert property (data_bus_oe |-> out_drive_n)
    else $error("Host drives while device output on");
  a_precharge_gap: assert property ($rose(chip_sel_n)
    |-> chip_sel_n [*6])
    else $error("Pre-charge interval violated");
  a_write_pulse_len: assert property ($fell(write_strobe_n)
    |-> !write_strobe_n [*5] ##1 write_strobe_n)
    else $error("Write strobe width wrong");
  a_write_edge_data: assert property ($rose(write_strobe_n)
    |-> data_bus_oe && $rose(chip_sel_n))
    else $error("Write data not held at latch edge");
  a_read_returns: assert property ($fell(out_drive_n)
    |-> ##6 rsp_valid)
    else $error("Read data not returned in time");
  a_sleep_idle_pins: assert property (!sleep_n |-> chip_sel_n && write_strobe_n
    && out_drive_n && !data_bus_oe)
    else $error("Pins active during sleep");

  c_read: cover property ($rose(rsp_valid));
  c_write: cover property ($rose(write_strobe_n));
  c_sleep: cover property ($fell(sleep_n));
  c_byte_write: cover property ($fell(write_strobe_n) && low_byte_lane_n);

endmodule : psnvm_host

/* sim/psnvm_mem_model.sv */
`timescale 1ns/10ps
// Behavioural word memory facing the host
module psnvm_mem_model
  import psnvm_pkg::*;
(
  input wire logic [ADDR_W-1:0] word_addr,
  input wire logic chip_sel_n,
  input wire logic write_strobe_n,
  input wire logic out_drive_n,
  input wire logic low_byte_lane_n,
  input wire logic high_byte_lane_n,
  input wire logic sleep_n,
  input wire logic [DATA_W-1:0] bus_in,
  output logic [DATA_W-1:0] bus_out,
  output logic [1:0] lane_oe
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // Full 18-bit word index
  logic wr_open = 1'b0; // Write cycle in progress
  logic rd_ok; // Read path active
  // Write opens on strobe fall, only when selected and awake
  always @(negedge write_strobe_n) if (!chip_sel_n && sleep_n) wr_open = 1'b1;
  // Earliest rising edge latches data, per enabled lane
  always @(posedge chip_sel_n or posedge write_strobe_n) begin
    if (wr_open && sleep_n) begin
      if (!low_byte_lane_n) mem[word_addr][7:0] = bus_in[7:0];
      if (!high_byte_lane_n) mem[word_addr][15:8] = bus_in[15:8];
    end
    wr_open = 1'b0;
  end
  // Drive follows address at once; floats on standby, sleep, lanes off
  always @* begin
    rd_ok = !chip_sel_n && sleep_n && write_strobe_n && !out_drive_n;
    lane_oe = {rd_ok && !high_byte_lane_n, rd_ok && !low_byte_lane_n};
    bus_out = mem[word_addr];
  end
endmodule : psnvm_mem_model

/* sim/test_pseudo_sram_nv_memory_port.sv */
`timescale 1ns/10ps
module test_pseudo_sram_nv_memory_port;
  import psnvm_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, req_valid = 1'b0, req_ready, req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = 18'h00000, word_addr;
  logic [DATA_W-1:0] req_wdata = 16'h0000, rsp_rdata, data_bus_in, data_bus_out, mdl_out;
  logic [DATA_W-1:0] last_w = 16'h0000; // Floating lanes show its inverse
  logic [1:0] req_byte_en = 2'h3, lane_oe;
  logic sleep_req = 1'b0, rsp_valid, asleep, chip_sel_n, write_strobe_n, out_drive_n;
  logic low_byte_lane_n, high_byte_lane_n, sleep_n, data_bus_oe;
  int bad_count = 0, comparisons = 0;
  psnvm_host i_psnvm_host (.core_clk, .srst, .req_valid, .req_ready, .req_write, .req_addr,
    .req_wdata, .req_byte_en, .sleep_req, .rsp_valid, .rsp_rdata, .asleep, .word_addr,
    .chip_sel_n, .write_strobe_n, .out_drive_n, .low_byte_lane_n, .high_byte_lane_n,
    .sleep_n, .data_bus_in, .data_bus_out, .data_bus_oe);
  psnvm_mem_model i_psnvm_mem_model (.word_addr, .chip_sel_n, .write_strobe_n,
    .out_drive_n, .low_byte_lane_n, .high_byte_lane_n, .sleep_n, .bus_in(data_bus_in),
    .bus_out(mdl_out), .lane_oe);
  // Clock at 25 ns
  initial forever #12.5 core_clk = ~core_clk;
  // Shared bus resolution per lane
  always @* for (int i = 0; i < 2; i++)
    data_bus_in[i*8+:8] = data_bus_oe ? data_bus_out[i*8+:8] :
      lane_oe[i] ? mdl_out[i*8+:8] : ~last_w[i*8+:8];
  always @(posedge core_clk) last_w <= data_bus_in;
  task automatic check(input logic [DATA_W-1:0] seen, exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // Bounded wait has run out
  task automatic expire;
    bad_count++;
    tally_and_finish();
  endtask : expire
  // Never both parties on the bus; sleep stays high while selected
  always @(negedge core_clk) if (srst === 1'b0) begin
    check(data_bus_oe & (|lane_oe), 1'b0, "bus contention");
    if (chip_sel_n === 1'b0) check(sleep_n, 1'b1, "sleep in access");
  end
  // One request, held until taken
  task automatic do_req(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [1:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_byte_en <= be;
    do begin
      @(negedge core_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    if (n >= 100) expire();
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask : do_req
  // Full-word read compared with a value
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int n;
    do_req(1'b0, a, 16'h0000, 2'h3);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 20);
    if (n >= 20) expire();
    check(rsp_rdata, exp, "read data");
  endtask : rd_chk
  // Words at both ends of the address range, back to back
  task automatic sc_words;
    do_req(1'b1, 18'h3FFFF, 16'hA55A, 2'h3);
    do_req(1'b1, 18'h00000, 16'hC3C3, 2'h3);
    rd_chk(18'h3FFFF, 16'hA55A);
    rd_chk(18'h00000, 16'hC3C3);
  endtask : sc_words
  // Single lanes leave the other byte untouched
  task automatic sc_lanes;
    do_req(1'b1, 18'h3FFFF, 16'h1234, 2'h1);
    rd_chk(18'h3FFFF, 16'hA534);
    do_req(1'b1, 18'h3FFFF, 16'h5678, 2'h2);
    rd_chk(18'h3FFFF, 16'h5634);
    // No lane selected: the word must stay as it was
    do_req(1'b1, 18'h3FFFF, 16'hFFFF, 2'h0);
    rd_chk(18'h3FFFF, 16'h5634);
  endtask : sc_lanes
  // Sleep refuses requests, wake keeps contents
  task automatic sc_sleep;
    int n;
    n = 0;
    @(posedge core_clk);
    sleep_req <= 1'b1;
    do begin
      @(negedge core_clk);
      n++;
    end while (asleep !== 1'b1 && n < 50);
    if (n >= 50) expire();
    check(sleep_n, 1'b0, "sleep pin");
    check(chip_sel_n, 1'b1, "select in sleep");
    check(req_ready, 1'b0, "ready in sleep");
    @(posedge core_clk);
    sleep_req <= 1'b0;
    rd_chk(18'h00000, 16'hC3C3);
  endtask : sc_sleep
  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    check(chip_sel_n, 1'b1, "select at reset");
    sc_words();
    sc_lanes();
    sc_sleep();
    tally_and_finish();
  end
endmodule : test_pseudo_sram_nv_memory_port
